/* smcb_pkg.sv */
// shared types and constants for the macro configuration serial bus
package smcb_pkg;

    // width of each signal-detect hold time, counted in core_clk cycles
    localparam int DET_W = 8;

    // lane operating modes; skew adjust only counts in the first
    typedef enum logic [1:0]
    {
        SMCB_MODE_SGMII_1G,
        SMCB_MODE_SGMII_2G5,
        SMCB_MODE_SERDES_1G,
        SMCB_MODE_FX100
    } smcb_lane_mode_t;

    // one lane configuration word, most significant field shifted first
    typedef struct packed {
        logic                  sigdet_raw_sts;   // read-only status
        logic                  sigdet_pcs_sts;   // read-only status
        logic                  macro_system_reset; // 1 releases
        logic                  lane_reset;       // 1 holds lane
        smcb_lane_mode_t       lane_mode;
        logic                  facility_loopback;
        logic                  phase_align_enable;
        logic                  input_fibre100_enable;
        logic                  offset_comp_ac_enable;
        logic                  offset_comp_dc_enable;
        logic                  fibre_recovery_enable;
        logic [1:0]            recovery_mode_select;
        logic [4:0]            precursor_coeff;
        logic [5:0]            first_postcursor_coeff;
        logic [4:0]            second_postcursor_coeff;
        logic                  center_tap_polarity;
        logic [5:0]            amplitude_level;
        logic                  skew_adjust_enable;
        logic                  tx_low_power_idle_enable;
        logic                  rx_low_power_idle_enable;
        logic                  tx_invert_enable;
        logic                  rx_invert_enable;
        logic                  hyst_enable;
        logic [DET_W-1:0]      detect_assert_time;
        logic [DET_W-1:0]      detect_deassert_time;
    } smcb_cfg_t;

    localparam int CFG_W = $bits(smcb_cfg_t);

    // lane held in reset, non-inverting centre tap, offset comp on
    localparam smcb_cfg_t CFG_RESET = '{
        lane_mode             : SMCB_MODE_SGMII_1G,
        lane_reset            : 1'h1,
        center_tap_polarity   : 1'h1,
        offset_comp_ac_enable : 1'h1,
        offset_comp_dc_enable : 1'h1,
        default               : '0
    };

    // last count value of each frame; a read spends one cycle on the load
    localparam int WR_LAST = CFG_W - 1;
    localparam int RD_LAST = CFG_W;

    // pre-emphasis and amplitude arithmetic, fibre recovery mode value
    localparam logic [6:0] CENTER_TAP_FULL = 7'h40;
    localparam logic [6:0] AMP_OFFSET      = 7'h40;
    localparam logic [5:0] CENTER_TAP_MAX  = 6'h3F;
    localparam logic [1:0] FIBRE_CDR_MODE  = 2'h2;

endpackage

/* smcb_if.sv */
// serial configuration bus between the central loader and lane macros
`timescale 1ns/1ns
interface smcb_if #(
    parameter int NUM_MACRO = 4
);
    logic                 frame;
    logic                 dir_read;
    logic                 sdo;
    logic [NUM_MACRO-1:0] sel;
    wire  [NUM_MACRO-1:0] miso;

    modport ctrl_end
    (
        output frame,
        output dir_read,
        output sdo,
        output sel,
        input  miso
    );

    modport macro_end
    (
        input  frame,
        input  dir_read,
        input  sdo,
        input  sel,
        output miso
    );
endinterface

/* smcb_ctrl.sv */
// central configuration loader driving the fast and slow lane buses
`timescale 1ns/1ns
module smcb_ctrl import smcb_pkg::*; #(
    parameter int NUM_MACRO = 4
)
(
    input  wire logic                            core_clk,
    input  wire logic                            reset_n,
    smcb_if.ctrl_end                             fast_bus,
    smcb_if.ctrl_end                             slow_bus,
    input  wire logic [1:0]                      mask_load,
    input  wire logic [1:0][NUM_MACRO-1:0]       mask_data,
    input  wire logic [1:0]                      cfg_load,
    input  wire logic [1:0][CFG_W-1:0]           cfg_data,
    input  wire logic [1:0]                      write_start,
    input  wire logic [1:0]                      read_start,
    output logic      [1:0][NUM_MACRO-1:0]       macro_select_mask,
    output logic      [1:0][CFG_W-1:0]           central_cfg,
    output logic      [1:0]                      write_trigger,
    output logic      [1:0]                      read_trigger
);
    localparam int CW = $clog2(CFG_W + 1);

    // one channel: index 0 fast lanes, index 1 slow lanes
    typedef struct packed {
        logic [NUM_MACRO-1:0] mask;
        logic                 wr_trig;
        logic                 rd_trig;
        logic [CFG_W-1:0]     cfg;
        logic [CFG_W-1:0]     shreg;
        logic [CW-1:0]        cnt;
    } smcb_ch_t;

    typedef struct packed {
        smcb_ch_t [1:0] ch;
    } smcb_ctrl_st_t;

    smcb_ctrl_st_t             st;
    smcb_ctrl_st_t             next_st;
    logic [1:0][NUM_MACRO-1:0] miso_v;

    assign miso_v[0] = fast_bus.miso;
    assign miso_v[1] = slow_bus.miso;

    // next state for both channels; same procedure on each bus
    always_comb
    begin
        logic busy;
        logic bit_in;
        busy    = 1'h0;
        bit_in  = 1'h0;
        next_st = st;
        for (int i = 0; i < 2; i++)
        begin
            busy   = st.ch[i].wr_trig | st.ch[i].rd_trig;
            // unselected macros drive zero, so this ORs the set
            bit_in = |(miso_v[i] & st.ch[i].mask);
            // mask and central word are frozen while a transfer runs
            if (!busy && mask_load[i])
                next_st.ch[i].mask = mask_data[i];
            if (!busy && cfg_load[i])
                next_st.ch[i].cfg = cfg_data[i];
            // write wins when both starts arrive together
            if (!busy && write_start[i])
            begin
                next_st.ch[i].wr_trig = 1'h1;
                next_st.ch[i].cnt     = '0;
                next_st.ch[i].shreg   = cfg_load[i] ? cfg_data[i]
                                                    : st.ch[i].cfg;
            end
            else if (!busy && read_start[i])
            begin
                next_st.ch[i].rd_trig = 1'h1;
                next_st.ch[i].cnt     = '0;
            end
            // write frame: one bit per cycle, msb first
            if (st.ch[i].wr_trig)
            begin
                next_st.ch[i].shreg = {st.ch[i].shreg[CFG_W-2:0], 1'h0};
                next_st.ch[i].cnt   = st.ch[i].cnt + CW'(1);
                if (st.ch[i].cnt == CW'(WR_LAST))
                    next_st.ch[i].wr_trig = 1'h0;
            end
            // read frame: cycle 0 lets the macros load their snapshot
            if (st.ch[i].rd_trig)
            begin
                next_st.ch[i].cnt = st.ch[i].cnt + CW'(1);
                if (st.ch[i].cnt != '0)
                    next_st.ch[i].shreg = {st.ch[i].shreg[CFG_W-2:0],
                                           bit_in};
                if (st.ch[i].cnt == CW'(RD_LAST))
                begin
                    next_st.ch[i].rd_trig = 1'h0;
                    next_st.ch[i].cfg = {st.ch[i].shreg[CFG_W-2:0],
                                         bit_in};
                end
            end
        end
    end

    // single state register
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            st <= '0;
        else
            st <= next_st;
    end

    // bus drive; select lines only high inside a frame
    assign fast_bus.frame    = st.ch[0].wr_trig | st.ch[0].rd_trig;
    assign fast_bus.dir_read = st.ch[0].rd_trig;
    assign fast_bus.sdo      = st.ch[0].shreg[CFG_W-1] & st.ch[0].wr_trig;
    assign fast_bus.sel      = fast_bus.frame ? st.ch[0].mask : '0;
    assign slow_bus.frame    = st.ch[1].wr_trig | st.ch[1].rd_trig;
    assign slow_bus.dir_read = st.ch[1].rd_trig;
    assign slow_bus.sdo      = st.ch[1].shreg[CFG_W-1] & st.ch[1].wr_trig;
    assign slow_bus.sel      = slow_bus.frame ? st.ch[1].mask : '0;

    // software-visible state
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            macro_select_mask[i] = st.ch[i].mask;
            central_cfg[i]       = st.ch[i].cfg;
            write_trigger[i]     = st.ch[i].wr_trig;
            read_trigger[i]      = st.ch[i].rd_trig;
        end
    end
endmodule

/* smcb_lane.sv */
// lane macro end: config register on the serial bus plus digital options
`timescale 1ns/1ns
module smcb_lane import smcb_pkg::*; #(
    parameter int NUM_MACRO = 4,
    parameter int IDX       = 0,
    parameter int DATA_W    = 20
)
(
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    smcb_if.macro_end              bus,
    input  wire logic              sigdet_raw,
    input  wire logic              pcs_tx_buf_en,
    input  wire logic              pcs_rx_buf_en,
    input  wire logic [DATA_W-1:0] tx_data_in,
    input  wire logic [DATA_W-1:0] rx_data_in,
    output logic                   sigdet_pcs,
    output logic      [DATA_W-1:0] tx_data_out,
    output logic      [DATA_W-1:0] rx_data_out,
    output logic                   tx_buf_enable,
    output logic                   rx_buf_enable,
    output logic      [4:0]        precursor_val,
    output logic      [5:0]        first_postcursor_val,
    output logic      [4:0]        second_postcursor_val,
    output logic      [6:0]        center_tap_val,
    output logic      [6:0]        amplitude_coeff,
    output logic                   skew_adjust_active,
    output logic                   phase_align_active,
    output logic                   fibre_cdr_active,
    output logic                   offset_ac_active,
    output logic                   offset_dc_active,
    output logic                   lane_in_reset
);
    typedef struct packed {
        smcb_cfg_t        cfg;
        logic [CFG_W-1:0] shreg;
        logic             frame_q;
        logic             sel_q;
        logic             dir_q;
        logic             sig_rep;
        logic [DET_W-1:0] det_cnt;
        logic [DATA_W-1:0] tx_q;
        logic [DATA_W-1:0] rx_q;
    } smcb_lane_st_t;

    smcb_lane_st_t st;
    smcb_lane_st_t next_st;
    logic          selected;
    logic          frame_end;
    logic          lpi_handoff;
    logic [6:0]    tap_sum;
    logic [6:0]    tap_raw;
    logic [5:0]    tap_mag;
    logic [6:0]    pre_full;
    logic [6:0]    post0_full;
    logic [6:0]    post1_full;

    // sign-magnitude to two's complement, msb of the field is the sign
    function automatic logic [6:0] sm_val
    (
        input logic       neg,
        input logic [5:0] mag
    );
        logic [6:0] wide;
        wide = {1'h0, mag};
        sm_val = neg ? 7'(-wide) : wide;
    endfunction

    assign selected  = bus.frame & bus.sel[IDX];
    assign frame_end = st.frame_q & !bus.frame;

    // bus side, hysteresis and data path
    always_comb
    begin
        logic [DET_W-1:0] lim;
        logic [DET_W:0]   cnt_up;
        lim     = st.sig_rep ? st.cfg.detect_deassert_time
                             : st.cfg.detect_assert_time;
        cnt_up  = {1'h0, st.det_cnt} + 1'h1;
        next_st = st;
        next_st.frame_q = bus.frame;
        next_st.sel_q   = selected;
        next_st.dir_q   = bus.dir_read;

        // write frame: shift in one bit per cycle while selected
        if (selected && !bus.dir_read)
            next_st.shreg = {st.shreg[CFG_W-2:0], bus.sdo};
        // read frame: snapshot on the first cycle, then shift out
        if (selected && bus.dir_read)
        begin
            if (!st.frame_q)
                next_st.shreg = st.cfg;
            else
                next_st.shreg = {st.shreg[CFG_W-2:0], 1'h0};
        end
        // commit only after the frame closes, so a cut frame is dropped
        // only if the lane is reset along with the loader, as the bench does mid-frame
        if (frame_end && st.sel_q && !st.dir_q)
            next_st.cfg = smcb_cfg_t'(st.shreg);

        // signal-detect filter; counts in core_clk cycles
        if (!st.cfg.hyst_enable)
        begin
            next_st.sig_rep = sigdet_raw;
            next_st.det_cnt = '0;
        end
        else if (sigdet_raw == st.sig_rep)
            next_st.det_cnt = '0; // any blip restarts the hold time
        else if (cnt_up >= {1'h0, lim})
        begin
            next_st.sig_rep = sigdet_raw;
            next_st.det_cnt = '0;
        end
        else
            next_st.det_cnt = cnt_up[DET_W-1:0];

        // status fields always track live state; writes cannot hold them
        next_st.cfg.sigdet_raw_sts = sigdet_raw;
        next_st.cfg.sigdet_pcs_sts = st.sig_rep;

        // inversion acts as a p/n swap on each direction
        next_st.tx_q = tx_data_in ^ {DATA_W{st.cfg.tx_invert_enable}};
        next_st.rx_q = rx_data_in ^ {DATA_W{st.cfg.rx_invert_enable}};
    end

    // single state register
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            st <= '{cfg: CFG_RESET, default: '0};
        else
            st <= next_st;
    end

    // read data; unselected macros drive zero so the loader can OR
    assign bus.miso[IDX] = st.shreg[CFG_W-1] & st.sel_q
                           & st.dir_q & bus.frame;

    assign sigdet_pcs  = st.sig_rep;
    assign tx_data_out = st.tx_q;
    assign rx_data_out = st.rx_q;

    // lane needs both reset controls released
    assign lane_in_reset = st.cfg.lane_reset
                           | !st.cfg.macro_system_reset;

    // buffer activity handed to the pcs only when both enables set
    assign lpi_handoff   = st.cfg.tx_low_power_idle_enable
                           & st.cfg.rx_low_power_idle_enable;
    assign tx_buf_enable = lpi_handoff ? pcs_tx_buf_en
                                       : !lane_in_reset;
    assign rx_buf_enable = lpi_handoff ? pcs_rx_buf_en
                                       : !lane_in_reset;

    // pre-emphasis taps as two's complement
    assign pre_full   = sm_val(st.cfg.precursor_coeff[4],
                               {2'h0, st.cfg.precursor_coeff[3:0]});
    assign post0_full = sm_val(st.cfg.first_postcursor_coeff[5],
                               {1'h0, st.cfg.first_postcursor_coeff[4:0]});
    assign post1_full = sm_val(st.cfg.second_postcursor_coeff[4],
                               {2'h0, st.cfg.second_postcursor_coeff[3:0]});
    assign precursor_val         = pre_full[4:0];
    assign first_postcursor_val  = post0_full[5:0];
    assign second_postcursor_val = post1_full[4:0];

    // centre tap: 64 less the three magnitudes; 64 itself saturates
    // because the tap has only six magnitude bits
    assign tap_sum = {3'h0, st.cfg.precursor_coeff[3:0]}
                     + {2'h0, st.cfg.first_postcursor_coeff[4:0]}
                     + {3'h0, st.cfg.second_postcursor_coeff[3:0]};
    assign tap_raw = CENTER_TAP_FULL - tap_sum;
    assign tap_mag = tap_raw[6] ? CENTER_TAP_MAX : tap_raw[5:0];
    // polarity 1 is non-inverting, the normal setting
    assign center_tap_val = sm_val(!st.cfg.center_tap_polarity,
                                   tap_mag);

    // amplitude always lands in 64..127
    assign amplitude_coeff = AMP_OFFSET + {1'h0, st.cfg.amplitude_level};

    // skew adjust ignored outside sgmii 1g
    assign skew_adjust_active = st.cfg.skew_adjust_enable
                                & (st.cfg.lane_mode == SMCB_MODE_SGMII_1G);

    // loopback forces the aligner on
    assign phase_align_active = st.cfg.phase_align_enable
                                | st.cfg.facility_loopback;

    // recovery only when all three settings agree
    assign fibre_cdr_active = st.cfg.fibre_recovery_enable
                              & st.cfg.input_fibre100_enable
                              & (st.cfg.recovery_mode_select
                                 == FIBRE_CDR_MODE);

    // passed as programmed; software owns the fibre policy
    assign offset_ac_active = st.cfg.offset_comp_ac_enable;
    assign offset_dc_active = st.cfg.offset_comp_dc_enable;
endmodule

/* smcb_props.sv */
// concurrent checks on the fast lane configuration bus wires
`timescale 1ns/1ns
module smcb_props import smcb_pkg::*; #(
    parameter int NUM_MACRO = 4
)
(
    input wire logic                 core_clk,
    input wire logic                 reset_n,
    input wire logic                 frame,
    input wire logic                 dir_read,
    input wire logic                 sdo,
    input wire logic [NUM_MACRO-1:0] sel,
    input wire logic [NUM_MACRO-1:0] miso
);
    logic [7:0] cnt;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // frame length counter; a long repetition would unroll badly
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            cnt <= 8'h00;
        else
            cnt <= frame ? cnt + 8'h01 : 8'h00;
    end

    a_sel_idle_zero: assert property (!frame |-> sel == '0)
        else $error("select active outside a frame");
    a_sel_held: assert property (frame && $past(frame) |-> $stable(sel))
        else $error("select changed inside a frame");
    a_dir_held: assert property (frame && $past(frame) |-> $stable(dir_read))
        else $error("direction changed inside a frame");
    a_write_len: assert property ($fell(frame) && !$past(dir_read) |-> cnt == CFG_W)
        else $error("write frame length wrong");
    a_read_len: assert property ($fell(frame) && $past(dir_read) |-> cnt == CFG_W + 1)
        else $error("read frame length wrong");
    a_frame_bound: assert property (frame |-> cnt <= CFG_W)
        else $error("frame runs too long");
    a_miso_quiet: assert property (!(frame && dir_read) |-> miso == '0)
        else $error("return data outside a read");
    a_miso_in_mask: assert property (frame |-> (miso & ~sel) == '0)
        else $error("unselected macro answered");
    a_frame_min: assert property ($rose(frame) |-> frame [*8])
        else $error("frame ended too early");
endmodule

/* serdes_macro_config_bus_test.sv */
// self-checking bench joining the loader to four lane macros
`timescale 1ns/1ns
module serdes_macro_config_bus_test import smcb_pkg::*;;
    typedef struct {
        logic        b;
        logic [1:0]  wm;
        logic [63:0] w;
        logic [1:0]  rm;
    } smcb_row_t;
    // ordinary transfers: bus, write mask, word, read mask
    smcb_row_t rows[4] = '{
        '{1'h0, 2'h3, 64'h00C3A55C3B9E1247, 2'h1},
        '{1'h0, 2'h2, 64'h0012F0E1D2E3B4A5, 2'h3},
        '{1'h1, 2'h1, 64'h00FFFFFFFFFFFFFF, 2'h1},
        '{1'h0, 2'h0, 64'h0055AA55AA55AA55, 2'h3}};
    logic                  core_clk = 1'h0;
    logic                  reset_n = 1'h0;
    logic [1:0]            mask_load = '0, cfg_load = '0;
    logic [1:0]            write_start = '0, read_start = '0;
    logic [1:0][1:0]       mask_data = '0, msk;
    logic [1:0][CFG_W-1:0] cfg_data = '0, ccfg;
    logic [1:0]            wtrig, rtrig;
    logic [3:0]            sd_raw = '0;
    logic                  pcs_tx = 1'h1, pcs_rx = 1'h0;
    logic [19:0]           din = 20'h5A3C9, txo[4], rxo[4];
    logic [4:0]            pre[4], p3[4];
    logic [5:0]            p2[4];
    logic [6:0]            ctv[4], amp[4];
    logic                  sdp[4], txb[4], rxb[4], skw[4], pha[4], lir[4];
    logic                  cdr[4], oac[4], odc[4];
    smcb_cfg_t             mdl[4];
    int                    bad_count = 0, cmp_count = 0, cyc = 0;

    smcb_if #(.NUM_MACRO(2)) bus_if[2] ();

    smcb_ctrl #(.NUM_MACRO(2)) smcb_ctrl_i (.core_clk(core_clk),
        .reset_n(reset_n), .fast_bus(bus_if[0]), .slow_bus(bus_if[1]),
        .mask_load(mask_load), .mask_data(mask_data), .cfg_load(cfg_load),
        .cfg_data(cfg_data), .write_start(write_start),
        .read_start(read_start), .macro_select_mask(msk),
        .central_cfg(ccfg), .write_trigger(wtrig), .read_trigger(rtrig));

    // two lanes on each bus so every return line has a driver
    for (genvar g = 0; g < 4; g++)
    begin : gl
        smcb_lane #(.NUM_MACRO(2), .IDX(g % 2)) smcb_lane_i (
            .core_clk(core_clk), .reset_n(reset_n), .bus(bus_if[g / 2]),
            .sigdet_raw(sd_raw[g]), .pcs_tx_buf_en(pcs_tx),
            .pcs_rx_buf_en(pcs_rx), .tx_data_in(din), .rx_data_in(din),
            .sigdet_pcs(sdp[g]), .tx_data_out(txo[g]), .rx_data_out(rxo[g]),
            .tx_buf_enable(txb[g]), .rx_buf_enable(rxb[g]),
            .precursor_val(pre[g]), .first_postcursor_val(p2[g]),
            .second_postcursor_val(p3[g]), .center_tap_val(ctv[g]),
            .amplitude_coeff(amp[g]), .skew_adjust_active(skw[g]),
            .phase_align_active(pha[g]), .fibre_cdr_active(cdr[g]),
            .offset_ac_active(oac[g]), .offset_dc_active(odc[g]),
            .lane_in_reset(lir[g]));
    end

    smcb_props #(.NUM_MACRO(2)) smcb_props_i (.core_clk(core_clk),
        .reset_n(reset_n), .frame(bus_if[0].frame),
        .dir_read(bus_if[0].dir_read), .sdo(bus_if[0].sdo),
        .sel(bus_if[0].sel), .miso(bus_if[0].miso));

    // clock and hang guard
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            bad_count = bad_count + 1;
            tally_and_finish;
        end
    end

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(logic [63:0] seen, logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    // sign-magnitude to two's complement, 7 bits wide
    function automatic logic [6:0] sm(logic neg, logic [6:0] mag);
        return neg ? 7'h00 - mag : mag;
    endfunction

    // expected lane outputs worked out from the modelled word
    task automatic chk_lane(int i);
        smcb_cfg_t c;
        logic [6:0] m;
        logic       off;
        logic       lpi;
        logic       fx;
        c = mdl[i];
        fx = c.fibre_recovery_enable && c.input_fibre100_enable
             && (c.recovery_mode_select == FIBRE_CDR_MODE);
        off = c.lane_reset || !c.macro_system_reset;
        lpi = c.tx_low_power_idle_enable && c.rx_low_power_idle_enable;
        m = 7'h40 - 7'(c.precursor_coeff[3:0]);
        m = m - 7'(c.first_postcursor_coeff[4:0]);
        m = m - 7'(c.second_postcursor_coeff[3:0]);
        if (m > 7'h3F)
            m = 7'h3F;
        check(pre[i], 5'(sm(c.precursor_coeff[4], 7'(c.precursor_coeff[3:0]))));
        check(p2[i], 6'(sm(c.first_postcursor_coeff[5], 7'(c.first_postcursor_coeff[4:0]))));
        check(p3[i], 5'(sm(c.second_postcursor_coeff[4], 7'(c.second_postcursor_coeff[3:0]))));
        check(ctv[i], sm(!c.center_tap_polarity, m));
        check(amp[i], 7'h40 + 7'(c.amplitude_level));
        check(skw[i], c.skew_adjust_enable && c.lane_mode == SMCB_MODE_SGMII_1G);
        check(lir[i], off);
        check(txb[i], lpi ? pcs_tx : !off);
        check(rxb[i], lpi ? pcs_rx : !off);
        check(txo[i], din ^ {20{c.tx_invert_enable}});
        check(rxo[i], din ^ {20{c.rx_invert_enable}});
        check(pha[i], c.phase_align_enable || c.facility_loopback);
        check(cdr[i], fx);
        check(oac[i], c.offset_comp_ac_enable);
        check(odc[i], c.offset_comp_dc_enable);
    endtask

    // load mask and word, start, wait for the trigger to drop
    task automatic xfer(logic b, logic [1:0] m, smcb_cfg_t c, logic rd,
                        logic poke);
        int n;
        @(posedge core_clk);
        mask_load[b] <= 1'h1;
        mask_data[b] <= m;
        cfg_load[b] <= 1'h1;
        cfg_data[b] <= c;
        @(posedge core_clk);
        mask_load[b] <= 1'h0;
        cfg_load[b] <= 1'h0;
        read_start[b] <= rd;
        write_start[b] <= !rd;
        @(posedge core_clk);
        read_start[b] <= 1'h0;
        write_start[b] <= 1'h0;
        #1;
        check(rd ? rtrig[b] : wtrig[b], 1'h1);
        n = 0;
        while ((wtrig[b] | rtrig[b]) && n < 200)
        begin
            @(posedge core_clk);
            // requests while busy must be dropped without trace
            if (poke && n == 3)
            begin
                read_start[b] <= 1'h1;
                mask_load[b] <= 1'h1;
                mask_data[b] <= ~m;
                cfg_load[b] <= 1'h1;
                cfg_data[b] <= ~c;
            end
            if (poke && n == 4)
            begin
                read_start[b] <= 1'h0;
                mask_load[b] <= 1'h0;
                cfg_load[b] <= 1'h0;
            end
            #1;
            n++;
        end
        check(n, rd ? CFG_W + 1 : CFG_W);
    endtask

    // move raw detect and count cycles until the filtered one follows
    task automatic det(int i, logic v, int lo, int hi);
        int n;
        @(posedge core_clk);
        sd_raw[i] <= v;
        n = 0;
        do
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        while (sdp[i] !== v && n < 20);
        check(n >= lo && n <= hi, 1'h1);
    endtask

    // a short pulse of raw detect must not reach the filtered output
    task automatic pulse(logic v, int k);
        @(posedge core_clk);
        sd_raw[0] <= v;
        repeat (k) @(posedge core_clk);
        sd_raw[0] <= !v;
        repeat (8) @(posedge core_clk);
        #1;
        check(sdp[0], !v);
    endtask

    initial
    begin
        smcb_cfg_t c;
        smcb_cfg_t e;
        foreach (mdl[i])
            mdl[i] = CFG_RESET;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'h1;
        repeat (3) @(posedge core_clk);
        #1;
        for (int i = 0; i < 4; i++)
            chk_lane(i);
        det(0, 1'h1, 1, 1);
        det(0, 1'h0, 1, 1);
        foreach (rows[k])
        begin
            c = smcb_cfg_t'(rows[k].w[CFG_W-1:0]);
            c.sigdet_raw_sts = 1'h0;
            c.sigdet_pcs_sts = 1'h0;
            c.macro_system_reset = 1'h1;
            c.lane_reset = 1'h0;
            xfer(rows[k].b, rows[k].wm, c, 1'h0, 1'h0);
            e = '0;
            for (int l = 0; l < 2; l++)
            begin
                if (rows[k].wm[l])
                    mdl[rows[k].b * 2 + l] = c;
                if (rows[k].rm[l])
                    e = e | mdl[rows[k].b * 2 + l];
            end
            xfer(rows[k].b, rows[k].rm, '0, 1'h1, 1'h0);
            check(ccfg[rows[k].b], e);
            for (int i = 0; i < 4; i++)
                chk_lane(i);
        end
        // hysteresis word, written while stray requests hit the bus
        c = CFG_RESET;
        c.lane_reset = 1'h0;
        c.macro_system_reset = 1'h1;
        c.hyst_enable = 1'h1;
        c.detect_assert_time = 8'h03;
        c.detect_deassert_time = 8'h05;
        c.center_tap_polarity = 1'h1;
        // fibre setup, plus a skew adjust that this mode must ignore
        c.lane_mode = SMCB_MODE_FX100;
        c.skew_adjust_enable = 1'h1;
        c.fibre_recovery_enable = 1'h1;
        c.input_fibre100_enable = 1'h1;
        c.recovery_mode_select = FIBRE_CDR_MODE;
        c.offset_comp_ac_enable = 1'h0;
        c.offset_comp_dc_enable = 1'h0;
        xfer(1'h0, 2'h1, c, 1'h0, 1'h1);
        mdl[0] = c;
        check(rtrig[0], 1'h0);
        check(ccfg[0], c);
        check(msk[0], 2'h1);
        pulse(1'h1, 2);
        chk_lane(0);
        det(0, 1'h1, 3, 4);
        pulse(1'h0, 4);
        det(0, 1'h0, 5, 6);
        // reset in mid-frame must abort and restore defaults
        @(posedge core_clk);
        write_start[0] <= 1'h1;
        @(posedge core_clk);
        write_start[0] <= 1'h0;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'h0;
        #1;
        check(wtrig[0], 1'h0);
        check(bus_if[0].frame, 1'h0);
        repeat (5) @(posedge core_clk);
        reset_n <= 1'h1;
        foreach (mdl[i])
            mdl[i] = CFG_RESET;
        repeat (3) @(posedge core_clk);
        #1;
        check(ccfg[0], '0);
        for (int i = 0; i < 4; i++)
            chk_lane(i);
        tally_and_finish;
    end
endmodule
